// [src/timer16_compare_capture.sv]
// 16-bit up-counter with two compare/capture registers
//
// Notes on behaviour
// - Zero first compare: interrupt on wrap, except in match-clear mode
// - First interrupt: match, edge b, one-shot
// - Shared pin: edge b input or output
// - Read racing capture undefined; capture correct
// - Stop racing capture: captured value undefined
// - Zero second compare: interrupt on wrap
// - Second interrupt: match, edge a, one-shot
// - Second compare writable while running
// - Nonzero mode field starts, zero stops
// - Overflow flag on wrap with max compare
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defines.svh"

module timer16_compare_capture (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic count_tick,
  input wire logic [1:0] timer_mode_ctrl,
  input wire logic capture_a_en,
  input wire logic capture_b_en,
  input wire logic ccr_a_wr,
  input wire logic ccr_b_wr,
  input wire logic [15:0] wr_data,
  input wire logic one_shot_trig,
  input wire logic overflow_clr,
  input wire logic edge_input_a,
  input wire logic shared_pin_is_output,
  input wire logic shared_port_pin_in,
  output logic [15:0] timer_count_value,
  output logic [15:0] compare_capture_reg_a,
  output logic [15:0] compare_capture_reg_b,
  output logic match_irq_a,
  output logic match_irq_b,
  output logic counter_overflow_flag,
  output logic timer_output_pin,
  output logic shared_port_pin_oe
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] sync_a_reg; // Edge input a, three stages
  logic [2:0] sync_b_reg; // Shared pin as edge input b
  logic edge_a; // Rising edge seen on input a
  logic edge_b; // Rising edge seen on input b
  logic edge_b_valid; // Edge b only when pin is an input
  timer16_pkg::timer_mode_t mode; // Decoded mode field
  logic running; // Counter enabled by mode
  logic [15:0] count_next; // Count after this tick
  logic wrap; // Count going max to zero
  logic wrap_step; // Count going zero to one after wrap
  logic wrapped_reg; // Last tick wrapped past max
  logic match_a; // Counter equals compare a
  logic match_b; // Counter equals compare b
  logic clear_on_match; // Match-clear mode reached compare a
  logic agree_a; // Stages 2 and 3 of input a agree
  logic agree_b; // Stages 2 and 3 of input b agree
  logic level_a_reg; // Filtered level of input a
  logic level_b_reg; // Filtered level of input b

  // Stage 1 feeds only stage 2; edges use stages 2 and 3
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_a_reg <= 3'h0;
      sync_b_reg <= 3'h0;
    end else begin
      sync_a_reg <= {sync_a_reg[1:0], edge_input_a};
      sync_b_reg <= {sync_b_reg[1:0], shared_port_pin_in};
    end
  end

  // A change counts only once stages 2 and 3 agree
  assign agree_a = (sync_a_reg[1] == sync_a_reg[2]);
  assign agree_b = (sync_b_reg[1] == sync_b_reg[2]);
  assign edge_a = agree_a & sync_a_reg[2] & ~level_a_reg;
  assign edge_b = agree_b & sync_b_reg[2] & ~level_b_reg;

  // Filtered levels; a one-cycle glitch never reaches them
  // Reset low matches the idle pins, so no false edge follows reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_a_reg <= 1'h0;
      level_b_reg <= 1'h0;
    end else begin
      if (agree_a) begin
        level_a_reg <= sync_a_reg[2];
      end
      if (agree_b) begin
        level_b_reg <= sync_b_reg[2];
      end
    end
  end

  // Pin serves one role only; edges ignored while it drives out
  assign edge_b_valid = edge_b & ~shared_pin_is_output;

  // ****************************************
  // Mode and counter
  // ****************************************
  assign mode = timer16_pkg::timer_mode_t'(timer_mode_ctrl);
  // Any nonzero field runs the counter at once
  assign running = (timer_mode_ctrl != `MODE_STOP);
  assign count_next = timer_count_value + `CNT_ONE;
  assign wrap = running && count_tick && (timer_count_value == `CNT_MAX);
  assign wrap_step = running && count_tick && wrapped_reg &&
                     (timer_count_value == `CNT_ZERO);
  assign match_a = (timer_count_value == compare_capture_reg_a) &&
                   !capture_a_en;
  assign match_b = (timer_count_value == compare_capture_reg_b) &&
                   !capture_b_en;
  // Software keeps compare a nonzero here, so zero never clears
  assign clear_on_match = (mode == timer16_pkg::MODE_CLEAR_ON_MATCH) &&
                          match_a && count_tick;

  // Counter: tick increments, wraps, clears on stop or trigger
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_count_value <= `CNT_RESET;
    end else if (!running) begin
      timer_count_value <= `CNT_ZERO;
    end else if (one_shot_trig) begin
      timer_count_value <= `CNT_ZERO;
    end else if ((mode == timer16_pkg::MODE_CLEAR_ON_EDGE) && edge_a) begin
      timer_count_value <= `CNT_ZERO;
    end else if (clear_on_match) begin
      timer_count_value <= `CNT_ZERO;
    end else if (count_tick) begin
      timer_count_value <= count_next;
    end
  end

  // Remembers a wrap until the next tick leaves zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrapped_reg <= 1'h0;
    end else if (!running) begin
      wrapped_reg <= 1'h0;
    end else if (count_tick) begin
      wrapped_reg <= wrap;
    end
  end

  // ****************************************
  // Compare/capture registers
  // ****************************************
  // Capture wins over a write; a racing stop may capture garbage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      compare_capture_reg_a <= `CCR_RESET;
    end else if (capture_a_en && edge_b_valid) begin
      compare_capture_reg_a <= timer_count_value;
    end else if (ccr_a_wr && !running) begin
      compare_capture_reg_a <= wr_data;
    end
  end

  // Compare b takes writes even while counting
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      compare_capture_reg_b <= `CCR_RESET;
    end else if (capture_b_en && edge_a) begin
      compare_capture_reg_b <= timer_count_value;
    end else if (ccr_b_wr) begin
      compare_capture_reg_b <= wr_data;
    end
  end

  // ****************************************
  // Interrupts and overflow
  // ****************************************
  // First interrupt: match, edge b, one-shot, or zero compare wrap outside match-clear mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      match_irq_a <= 1'h0;
    end else begin
      match_irq_a <= running && (
        (match_a && count_tick && compare_capture_reg_a != `CNT_ZERO) ||
        edge_b_valid || one_shot_trig ||
        (wrap_step && compare_capture_reg_a == `CNT_ZERO &&
         mode != timer16_pkg::MODE_CLEAR_ON_MATCH));
    end
  end

  // Second interrupt: match, edge a, one-shot, or zero compare wrap
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      match_irq_b <= 1'h0;
    end else begin
      match_irq_b <= running && (
        (match_b && count_tick && compare_capture_reg_b != `CNT_ZERO) ||
        edge_a || one_shot_trig ||
        (wrap_step && compare_capture_reg_b == `CNT_ZERO));
    end
  end

  // Sticky overflow; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      counter_overflow_flag <= 1'h0;
    end else if (wrap && compare_capture_reg_a == `CNT_MAX) begin
      counter_overflow_flag <= 1'h1;
    end else if (overflow_clr) begin
      counter_overflow_flag <= 1'h0;
    end
  end

  // ****************************************
  // Timer output on the shared pin
  // ****************************************
  // Toggles on a match with compare a; drives only in output role
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_output_pin <= 1'h0;
      shared_port_pin_oe <= 1'h0;
    end else begin
      shared_port_pin_oe <= shared_pin_is_output;
      if (!running) begin
        timer_output_pin <= 1'h0;
      end else if (match_a && count_tick) begin
        timer_output_pin <= ~timer_output_pin;
      end
    end
  end

  // Capture pulses must last at least two clock cycles to be seen

endmodule

`default_nettype wire

// [src/timer16_defines.svh]
// Constants for the 16-bit compare/capture timer
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH
`define CNT_MAX 16'hFFFF
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define CNT_RESET 16'h0000
`define CCR_RESET 16'h0000
`define MODE_STOP 2'h0
`define MODE_EDGE_CLR 2'h1
`define MODE_FREE 2'h2
`define MODE_MATCH_CLR 2'h3
`define SYNC_DEPTH 3
`endif

// [src/timer16_pkg.sv]
// Types for the 16-bit compare/capture timer
`default_nettype none
package timer16_pkg;
  typedef enum logic [1:0] {
    MODE_STOPPED = 2'b00,
    MODE_CLEAR_ON_EDGE = 2'b01,
    MODE_FREE_RUN = 2'b10,
    MODE_CLEAR_ON_MATCH = 2'b11
  } timer_mode_t;
endpackage
`default_nettype wire

// [tb/edge_source.sv]
// Model of an external trigger pin driving one edge input
`timescale 1ns/1ps
`default_nettype none
module edge_source (
  input wire logic clk,
  input wire logic fire,
  output logic pin
);
  // Cycles left in the pulse; the pin idles low between pulses
  logic [2:0] left_reg = 3'h0;
  // Request seen at the rising edge, so no race with the driver
  logic fire_seen_reg = 1'h0;
  always @(posedge clk) begin
    fire_seen_reg <= fire;
  end
  // Six cycles high, well past two count clocks, so capture is safe
  always @(negedge clk) begin
    if (fire_seen_reg) left_reg <= 3'h6;
    else if (left_reg != 3'h0) left_reg <= left_reg - 3'h1;
  end
  assign pin = left_reg != 3'h0;
endmodule
`default_nettype wire

// [tb/timer16_assertions.sv]
// Port checker for the compare/capture timer
`timescale 1ns/1ps
`default_nettype none
module timer16_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic count_tick,
  input wire logic capture_a_en,
  input wire logic capture_b_en,
  input wire logic one_shot_trig,
  input wire logic overflow_clr,
  input wire logic shared_pin_is_output,
  input wire logic match_irq_a,
  input wire logic match_irq_b,
  input wire logic counter_overflow_flag,
  input wire logic shared_port_pin_oe,
  input wire logic [1:0] timer_mode_ctrl,
  input wire logic [15:0] timer_count_value,
  input wire logic [15:0] compare_capture_reg_a,
  input wire logic [15:0] compare_capture_reg_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Short names; a tick counts only without a one-shot clear
  wire [15:0] c = timer_count_value;
  wire [15:0] a = compare_capture_reg_a;
  wire [15:0] b = compare_capture_reg_b;
  wire run = timer_mode_ctrl != 2'h0;
  wire step = run && count_tick && !one_shot_trig;
  stop_zero_a: assert property (!run |=> c == 16'h0000)
    else $error("count not cleared");
  irq_a_hit_a: assert property (
    step && !capture_a_en && a != 16'h0000 && c == a |=> match_irq_a)
    else $error("no irq a");
  irq_b_hit_a: assert property (
    step && !capture_b_en && b != 16'h0000 && c == b |=> match_irq_b)
    else $error("no irq b");
  one_shot_a: assert property (
    one_shot_trig && run |=> match_irq_a && match_irq_b && c == 16'h0000)
    else $error("one shot missed");
  ovf_set_a: assert property (
    step && timer_mode_ctrl == 2'h2 && a == 16'hFFFF && c == 16'hFFFF
    |=> counter_overflow_flag && c == 16'h0000) else $error("no overflow");
  ovf_hold_a: assert property (
    counter_overflow_flag && !overflow_clr |=> counter_overflow_flag)
    else $error("overflow dropped");
  pin_role_a: assert property (
    1'h1 |=> shared_port_pin_oe == $past(shared_pin_is_output))
    else $error("pin role wrong");
  ccr_a_lock_a: assert property (
    run && !capture_a_en |=> $stable(a)) else $error("ccr a changed");
  // Free-run mode has no clear source besides the one-shot
  count_step_a: assert property (
    step && timer_mode_ctrl == 2'h2 |=> c == $past(c) + 16'h0001)
    else $error("count did not step");
  irq_idle_a: assert property (
    !run |=> !match_irq_a && !match_irq_b) else $error("irq while stopped");
  cover property (match_irq_b);
  cover property (match_irq_a && capture_a_en);
  cover property (one_shot_trig && run);
  cover property (counter_overflow_flag);
endmodule
bind timer16_compare_capture timer16_checker port_checker (
  .clk(clk),
  .reset_n(reset_n),
  .count_tick(count_tick),
  .capture_a_en(capture_a_en),
  .capture_b_en(capture_b_en),
  .one_shot_trig(one_shot_trig),
  .overflow_clr(overflow_clr),
  .shared_pin_is_output(shared_pin_is_output),
  .match_irq_a(match_irq_a),
  .match_irq_b(match_irq_b),
  .counter_overflow_flag(counter_overflow_flag),
  .shared_port_pin_oe(shared_port_pin_oe),
  .timer_mode_ctrl(timer_mode_ctrl),
  .timer_count_value(timer_count_value),
  .compare_capture_reg_a(compare_capture_reg_a),
  .compare_capture_reg_b(compare_capture_reg_b)
);
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the compare/capture timer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, reset_n = 1'b0, tick = 1'b0, ca = 1'b0, cb = 1'b0;
  logic wa = 1'b0, wb = 1'b0, shot = 1'b0, oclr = 1'b0, pout = 1'b0;
  logic fa = 1'b0, fb = 1'b0, ea, eb, ia, ib, ovf, tout, oe;
  logic [1:0] mode = 2'h0;
  logic [15:0] wd = 16'h0000, cnt, crb, cra;
  int err_total = 0, check_count = 0, na = 0, nb = 0, ba, bb, cyc = 0;
  // Rows: mode, ticks, expected count
  logic [33:0] rows [4] = '{{2'h1, 16'h0005, 16'h0005},
    {2'h2, 16'h0014, 16'h0014}, {2'h3, 16'h0005, 16'h0005},
    {2'h0, 16'h0003, 16'h0000}};
  timer16_compare_capture dut (.clk(clk), .reset_n(reset_n),
    .count_tick(tick), .timer_mode_ctrl(mode), .capture_a_en(ca),
    .capture_b_en(cb), .ccr_a_wr(wa), .ccr_b_wr(wb), .wr_data(wd),
    .one_shot_trig(shot), .overflow_clr(oclr), .edge_input_a(ea),
    .shared_pin_is_output(pout), .shared_port_pin_in(eb),
    .timer_count_value(cnt), .compare_capture_reg_a(cra),
    .compare_capture_reg_b(crb), .match_irq_a(ia), .match_irq_b(ib),
    .counter_overflow_flag(ovf), .timer_output_pin(tout),
    .shared_port_pin_oe(oe));
  edge_source src_a (.clk(clk), .fire(fa), .pin(ea));
  edge_source src_b (.clk(clk), .fire(fb), .pin(eb));
  initial forever #5 clk = ~clk;
  // Tally irq pulses; the cycle ceiling cuts a hang short
  always @(posedge clk) begin
    na <= na + ia;
    nb <= nb + ib;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      final_report;
    end
  end
  task automatic chk(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Ticks every cycle, then a two-cycle settle for the irq tally
  task automatic run(input logic [1:0] m, input int n);
    mode = m;
    tick = 1'b1;
    repeat (n) @(negedge clk);
    tick = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic wr(input logic sel_b, input logic [15:0] v);
    wd = v;
    wa = !sel_b;
    wb = sel_b;
    @(negedge clk);
    wa = 1'b0;
    wb = 1'b0;
    @(negedge clk);
  endtask
  // One trigger pulse on edge pin a or b, then time to settle
  task automatic pulse(input logic sel_b);
    fa = !sel_b;
    fb = sel_b;
    @(negedge clk);
    fa = 1'b0;
    fb = 1'b0;
    repeat (9) @(negedge clk);
  endtask
  // Checks the irq counts since the last snapshot, then resnaps
  task automatic irqs(input logic [15:0] ea_n, eb_n);
    chk(16'(na - ba), ea_n);
    chk(16'(nb - bb), eb_n);
    ba = na;
    bb = nb;
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    chk(cnt, 16'h0000);
    chk({13'h0, ia, ib, ovf}, 16'h0000);
    wr(1'b0, 16'h0010);
    foreach (rows[i]) begin
      run(rows[i][33:32], int'(rows[i][31:16]));
      chk(cnt, rows[i][15:0]);
      run(2'h0, 1);
      chk(cnt, 16'h0000);
    end
    ba = na;
    bb = nb;
    mode = 2'h2;
    wr(1'b1, 16'h0003);
    chk(crb, 16'h0003);
    run(2'h2, 5);
    irqs(16'h0000, 16'h0001);
    shot = 1'b1;
    @(negedge clk);
    shot = 1'b0;
    repeat (2) @(negedge clk);
    chk(cnt, 16'h0000);
    irqs(16'h0001, 16'h0001);
    pulse(1'b0);
    pulse(1'b1);
    irqs(16'h0001, 16'h0001);
    pout = 1'b1;
    pulse(1'b1);
    irqs(16'h0000, 16'h0000);
    chk({15'h0, oe}, 16'h0001);
    // Captures with the count held at five, edges on both pins
    run(2'h2, 5);
    irqs(16'h0000, 16'h0001);
    ca = 1'b1;
    cb = 1'b1;
    pout = 1'b0;
    pulse(1'b0);
    pulse(1'b1);
    chk(crb, 16'h0005);
    chk(cra, 16'h0005);
    chk({15'h0, oe}, 16'h0000);
    irqs(16'h0001, 16'h0001);
    ca = 1'b0;
    cb = 1'b0;
    // Clear on an edge of pin a, then clear on a match with a
    run(2'h0, 1);
    wr(1'b0, 16'h0004);
    run(2'h1, 7);
    pulse(1'b0);
    chk(cnt, 16'h0000);
    irqs(16'h0001, 16'h0002);
    run(2'h0, 1);
    run(2'h3, 5);
    chk(cnt, 16'h0000);
    chk({15'h0, tout}, 16'h0001);
    irqs(16'h0001, 16'h0000);
    run(2'h0, 1);
    wr(1'b0, 16'hFFFF);
    wr(1'b1, 16'h0000);
    irqs(16'h0000, 16'h0000);
    run(2'h2, 65537);
    chk(cnt, 16'h0001);
    chk({15'h0, ovf}, 16'h0001);
    irqs(16'h0001, 16'h0001);
    oclr = 1'b1;
    @(negedge clk);
    oclr = 1'b0;
    @(negedge clk);
    chk({15'h0, ovf}, 16'h0000);
    // Reset in mid-run clears the count and the registers
    mode = 2'h2;
    tick = 1'b1;
    repeat (3) @(negedge clk);
    reset_n = 1'b0;
    @(negedge clk);
    chk(cnt, 16'h0000);
    chk(cra, 16'h0000);
    chk({11'h0, ia, ib, ovf, tout, oe}, 16'h0000);
    mode = 2'h0;
    tick = 1'b0;
    @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    chk(cnt, 16'h0000);
    final_report;
  end
endmodule
`default_nettype wire
